/* File: bench/ofd_dec_chk.sv */
/* checker: ties decoded outputs to the instruction fields.
   assumes: bound to the decoder top, one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
module ofd_dec_chk
(
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic       insn_valid_i,
  input wire logic       implied_mode_i,
  input wire logic       modrm_ext_i,
  input wire logic [1:0] reg_src_i,
  input wire logic [2:0] opcode_reg_i,
  input wire logic       w_present_i,
  input wire logic       w_i,
  input wire logic [7:0] modrm_i,
  input wire logic       seg_use3_i,
  input wire logic [1:0] seg_select_two_bit_i,
  input wire logic [2:0] seg_select_three_bit_i,
  input wire logic       dec_valid_o,
  input wire logic       op_size_32_o,
  input wire logic       addr_size_32_o,
  input wire logic [2:0] gpr_index_o,
  input wire logic       gpr_byte_o,
  input wire logic       gpr_high_o,
  input wire logic [3:0] gpr_wr_mask_o,
  input wire logic [2:0] opcode_extension_bits_o,
  input wire logic       opcode_ext_valid_o,
  input wire logic [2:0] seg_sel_o,
  input wire logic       seg_invalid_o,
  input wire logic       modrm_expected_o,
  input wire logic       sib_expected_o
);
  // all checks on the core clock, quiet in reset
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  // instruction taken that carries addressing bytes
  sequence s_take;
    insn_valid_i && !implied_mode_i;
  endsequence
  // addressing byte that escapes to a scaled index byte
  sequence s_sib_esc;
    s_take ##0 (modrm_i[2:0] == 3'h4) && (modrm_i[7:6] != 2'h3);
  endsequence
  property p_dec_copy;
    dec_valid_o == $past(insn_valid_i);
  endproperty
  a_dec_copy: assert property (p_dec_copy)
    else $error("result strobe not one cycle after instruction");
  property p_full_reg;
    insn_valid_i && !(w_present_i && !w_i) |=>
      !gpr_byte_o && gpr_wr_mask_o == (op_size_32_o ? 4'hf : 4'h3);
  endproperty
  a_full_reg: assert property (p_full_reg)
    else $error("full width register not selected");
  property p_byte_lane;
    insn_valid_i && w_present_i && !w_i && reg_src_i == 2'h0 |=> gpr_byte_o &&
      gpr_high_o == ($past(opcode_reg_i) > 3'h3) &&
      gpr_index_o == ($past(opcode_reg_i) & 3'h3);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte register lane wrong");
  property p_seg2;
    insn_valid_i && !seg_use3_i |=>
      !seg_invalid_o && seg_sel_o == {1'b0, $past(seg_select_two_bit_i)};
  endproperty
  a_seg2: assert property (p_seg2)
    else $error("two bit segment code wrong");
  property p_seg_rsv;
    insn_valid_i && seg_use3_i && seg_select_three_bit_i[2:1] == 2'h3 |=>
      seg_invalid_o && seg_sel_o == 3'h3;
  endproperty
  a_seg_rsv: assert property (p_seg_rsv)
    else $error("reserved segment code not flagged");
  property p_implied;
    insn_valid_i && implied_mode_i |=>
      !modrm_expected_o && !sib_expected_o && !opcode_ext_valid_o;
  endproperty
  a_implied: assert property (p_implied)
    else $error("addressing bytes expected on implied mode");
  property p_sib;
    s_sib_esc |=> sib_expected_o == addr_size_32_o;
  endproperty
  a_sib: assert property (p_sib)
    else $error("scaled index byte decision wrong");
  property p_ext;
    s_take ##0 modrm_ext_i |=> opcode_ext_valid_o &&
      {5'h00, opcode_extension_bits_o} == (($past(modrm_i) >> 3) & 8'h07);
  endproperty
  a_ext: assert property (p_ext)
    else $error("opcode extension bits wrong");
endmodule // ofd_dec_chk
`default_nettype wire

/* File: bench/ofd_insn_src.sv */
/* alignment stage model: presents one instruction's fields for one cycle.
   assumes: the bench calls issue from one thread at a time. */
`timescale 1ns/1ns
`default_nettype none
module ofd_insn_src
(
  input  wire logic        clock_i,
  output var  logic        insn_valid_o,
  output var  logic [32:0] fields_o
);
  // idle until asked
  initial
  begin
    insn_valid_o = 1'b0;
    fields_o = 33'h0;
  end
  // one instruction a call; reserved segment codes only when the bench asks
  task automatic issue(input logic [32:0] v);
    @(posedge clock_i);
    insn_valid_o <= 1'b1;
    fields_o <= v;
    @(posedge clock_i);
    insn_valid_o <= 1'b0;
    fields_o <= ~v; // meaningless outside the valid cycle
  endtask
endmodule // ofd_insn_src
`default_nettype wire

/* File: bench/test_operand_field_decoder.sv */
/* testbench of the operand field decoder: apb master, instruction source.
   assumes: decoder, checker and source model compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module test_operand_field_decoder;
  logic        clock_i, srst_i, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  int          miscompares = 0, comparisons = 0;
  wire logic   pready, pslverr, ival, dv, op32, a32, obyte, gbyte, ghigh;
  wire logic   extv, seginv, mexp, sexp, mem;
  wire logic [31:0] prdata;
  wire logic [32:0] f;
  wire logic [3:0]  gmask;
  wire logic [2:0]  gidx, extb, seg, sidx, sbase;
  wire logic [1:0]  sscale, disp;
  ofd_insn_src src_u (.clock_i(clock_i), .insn_valid_o(ival), .fields_o(f));
  ofd_operand_field_decoder dut_u
  (
    .clock_i(clock_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .insn_valid_i(ival),
    .opsize_prefix_i(f[32]), .addrsize_prefix_i(f[31]), .implied_mode_i(f[30]),
    .modrm_ext_i(f[29]), .reg_src_i(f[28:27]), .opcode_reg_i(f[26:24]),
    .w_present_i(f[23]), .w_i(f[22]), .modrm_i(f[21:14]), .sib_i(f[13:6]),
    .seg_use3_i(f[5]), .seg_select_two_bit_i(f[4:3]), .seg_select_three_bit_i(f[2:0]),
    .dec_valid_o(dv), .op_size_32_o(op32), .addr_size_32_o(a32), .operand_byte_o(obyte),
    .gpr_index_o(gidx), .gpr_byte_o(gbyte), .gpr_high_o(ghigh), .gpr_wr_mask_o(gmask),
    .opcode_extension_bits_o(extb), .opcode_ext_valid_o(extv), .seg_sel_o(seg),
    .seg_invalid_o(seginv), .modrm_expected_o(mexp), .sib_expected_o(sexp),
    .mem_operand_o(mem), .sib_scale_o(sscale), .sib_index_o(sidx), .sib_base_o(sbase),
    .disp_size_o(disp)
  );
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one apb transfer; waits for the slave's ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16)
    begin
      miscompares++;
      $display("CHECK FAILED %0t: no ready from the register bus", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dec(input logic [32:0] v);
    src_u.issue(v);
    #1;
    check(dv, 1'b1);
  endtask
  // reset values, read back, unmapped offsets
  task automatic t_regs();
    for (int a = 0; a < 12; a += 4)
    begin
      apb(1'b0, a[11:0], 32'h0);
      check({err, rd}, 33'h0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check(err, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h3);
  endtask
  // default size flag, legacy mode, both prefixes, size bit
  task automatic t_sizes();
    logic [4:0] k;
    logic       dflt;
    for (int i = 0; i < 32; i++)
    begin
      k = i[4:0];
      apb(1'b1, 12'h000, {30'h0, k[4], k[3]});
      dec({k[2], k[1], 4'h0, 3'h5, 1'b1, k[0], 8'hc0, 8'h00, 6'h00});
      dflt = k[3] & ~k[4];
      check({op32, a32}, {dflt ^ k[2], dflt ^ k[1]});
      check(obyte, {~k[0]});
      check(gmask, k[0] ? ((dflt ^ k[2]) ? 4'hf : 4'h3) : 4'h2);
    end
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
  endtask
  // every selector code from each of the three sources
  task automatic t_gpr();
    logic [2:0] s;
    logic [2:0] op;
    logic [7:0] m;
    logic       by;
    for (int src = 0; src < 3; src++)
      for (int c = 0; c < 24; c++)
      begin
        s = c[2:0];
        op = (src == 0) ? s : ~s;
        m = {2'b11, (src == 1) ? s : ~s, (src == 2) ? s : ~s};
        dec({src[0], 3'h0, src[1:0], op, c >= 8, c >= 16, m, 8'h00, 6'h00});
        by = (c >= 8) && (c < 16);
        check({gidx, gbyte, ghigh}, by ? {1'b0, s[1:0], 1'b1, s[2]} : {s, 2'b00});
        check(gmask, by ? (s[2] ? 4'h2 : 4'h1) : ((src == 1) ? 4'hf : 4'h3));
      end
  endtask
  // both segment selector forms, reserved codes counted
  task automatic t_seg();
    for (int c = 0; c < 16; c++)
    begin
      dec({11'h0, 8'hc0, 8'h00, c[3], c[1:0], c[2:0]});
      check({seginv, seg}, !c[3] ? {2'b00, c[1:0]} :
        ((c[2:1] == 2'b11) ? 4'hb : {1'b0, c[2:0]}));
    end
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
  endtask
  // expected e: addressing byte, scaled index, memory, displacement, extension
  task automatic t_am(input logic p, input logic im, input logic ex,
                      input logic [7:0] m, input logic [5:0] e);
    dec({1'b0, p, im, ex, 2'h1, 5'h0, m, 8'hd7, 6'h00});
    check({mexp, sexp, mem, extv}, {e[5:3], e[0]});
    check({sscale, sidx, sbase}, e[4] ? 8'hd7 : 8'h00);
    if (!im)
      check(disp, e[2:1]);
    if (ex)
      check(extb, m[5:3]);
  endtask
  task automatic t_addr();
    t_am(1'b1, 1'b0, 1'b0, 8'h04, 6'b111000);
    t_am(1'b1, 1'b0, 1'b0, 8'h84, 6'b111110);
    t_am(1'b1, 1'b0, 1'b0, 8'hc4, 6'b100000);
    t_am(1'b0, 1'b0, 1'b0, 8'h44, 6'b101010);
    t_am(1'b0, 1'b0, 1'b0, 8'h06, 6'b101100);
    t_am(1'b1, 1'b0, 1'b0, 8'h05, 6'b101110);
    t_am(1'b1, 1'b1, 1'b1, 8'h04, 6'b000000);
    t_am(1'b0, 1'b0, 1'b1, 8'h68, 6'b101011);
  endtask
  // free running core clock
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // reset, then the scenarios in turn
  initial
  begin
    srst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    t_regs();
    t_sizes();
    t_gpr();
    t_seg();
    t_addr();
    wrap_up();
  end
  // cuts a hang short
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule // test_operand_field_decoder
bind ofd_operand_field_decoder ofd_dec_chk chk_u
(
  .clock_i(clock_i), .srst_i(srst_i), .insn_valid_i(insn_valid_i),
  .implied_mode_i(implied_mode_i), .modrm_ext_i(modrm_ext_i), .reg_src_i(reg_src_i),
  .opcode_reg_i(opcode_reg_i), .w_present_i(w_present_i), .w_i(w_i), .modrm_i(modrm_i),
  .seg_use3_i(seg_use3_i), .seg_select_two_bit_i(seg_select_two_bit_i),
  .seg_select_three_bit_i(seg_select_three_bit_i), .dec_valid_o(dec_valid_o),
  .op_size_32_o(op_size_32_o), .addr_size_32_o(addr_size_32_o),
  .gpr_index_o(gpr_index_o), .gpr_byte_o(gpr_byte_o), .gpr_high_o(gpr_high_o),
  .gpr_wr_mask_o(gpr_wr_mask_o), .opcode_extension_bits_o(opcode_extension_bits_o),
  .opcode_ext_valid_o(opcode_ext_valid_o), .seg_sel_o(seg_sel_o),
  .seg_invalid_o(seg_invalid_o), .modrm_expected_o(modrm_expected_o),
  .sib_expected_o(sib_expected_o)
);
`default_nettype wire

/* File: hw/ofd_gpr_decode.v */
/*
  general register selector decode: turns a three bit selector, the
  operand-size bit and the operation size into a register number, byte
  flags and a write lane mask.
  assumes: purely combinational, driven and sampled by the parent.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ofd_consts.vh"

module ofd_gpr_decode
(
  input  wire [2:0] sel_i,
  input  wire       w_present_i,
  input  wire       w_i,
  input  wire       op32_i,
  output reg  [2:0] gpr_index_o,
  output reg        gpr_byte_o,
  output reg        gpr_high_o,
  output reg  [3:0] wr_mask_o
);

  // byte registers only when the size bit exists and is zero
  always @*
  begin
    if (w_present_i && !w_i)
    begin
      // low bytes for 000-011, high bytes of the same four for 100-111
      gpr_byte_o  = 1'b1;
      gpr_high_o  = sel_i[2];
      gpr_index_o = {1'b0, sel_i[1:0]};
      // upper lanes of the register stay untouched
      wr_mask_o   = sel_i[2] ? `OFD_MASK_HIGH_BYTE : `OFD_MASK_LOW_BYTE;
    end
    else
    begin
      // full width: accumulator .. destination index in code order
      gpr_byte_o  = 1'b0;
      gpr_high_o  = 1'b0;
      gpr_index_o = sel_i;
      wr_mask_o   = op32_i ? `OFD_MASK_DWORD : `OFD_MASK_WORD;
    end
  end

endmodule // ofd_gpr_decode

`default_nettype wire

/* File: hw/ofd_operand_field_decoder.v */
/*
  operand field decoder: decodes operand size, general register selector,
  segment selectors and addressing byte layout of one instruction per
  valid cycle, with results held in output flops; control and status over
  an apb slave.
  assumes: instruction fields come from the byte alignment stage on the same
  clock; prefix and opcode parsing are done upstream.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ofd_consts.vh"

// How it works
// - every data instruction runs at 16-bit or 32-bit operation size
// - size bit 0 gives byte operand, 1 gives the full operation size
// - register selector comes from opcode, addressing reg field or rm field
// - without size bit, codes 000-111 pick the eight full registers in order
// - size bit 0 picks low bytes 000-011, high bytes 100-111
// - two bit segment selector: extra, code, stack, data
// - three bit form adds two auxiliary segments; 110 and 111 unused
// - implied addressing instructions carry no addressing bytes
// - first addressing byte is primary, optional scaled index byte second
// - scaled index byte only in 32-bit addressing, rm 100, mod not 11
// - with scaled index byte, mode comes from mod, scale, index, base
// - middle addressing bits are opcode extension or register selector
// - addressing byte read per 16-bit or 32-bit address size
// - size prefixes invert the default sizes for one instruction only
// - real and compatibility modes force a 16-bit default
// - byte and word writes leave upper register bits unchanged
module ofd_operand_field_decoder
(
  input  wire        clock_i,
  input  wire        srst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // instruction fields from the alignment stage
  input  wire        insn_valid_i,
  input  wire        opsize_prefix_i,
  input  wire        addrsize_prefix_i,
  input  wire        implied_mode_i,
  input  wire        modrm_ext_i,
  input  wire [1:0]  reg_src_i,
  input  wire [2:0]  opcode_reg_i,
  input  wire        w_present_i,
  input  wire        w_i,
  input  wire [7:0]  modrm_i,
  input  wire [7:0]  sib_i,
  input  wire        seg_use3_i,
  input  wire [1:0]  seg_select_two_bit_i,
  input  wire [2:0]  seg_select_three_bit_i,
  // decoded results
  output wire        dec_valid_o,
  output wire        op_size_32_o,
  output wire        addr_size_32_o,
  output wire        operand_byte_o,
  output wire [2:0]  gpr_index_o,
  output wire        gpr_byte_o,
  output wire        gpr_high_o,
  output wire [3:0]  gpr_wr_mask_o,
  output wire [2:0]  opcode_extension_bits_o,
  output wire        opcode_ext_valid_o,
  output wire [2:0]  seg_sel_o,
  output wire        seg_invalid_o,
  output wire        modrm_expected_o,
  output wire        sib_expected_o,
  output wire        mem_operand_o,
  output wire [1:0]  sib_scale_o,
  output wire [2:0]  sib_index_o,
  output wire [2:0]  sib_base_o,
  output wire [1:0]  disp_size_o
);

  // apb and control state
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [1:0]  ctrl_reg;
  reg  [15:0] errcnt_reg;

  // decode result flops
  reg         dec_valid_reg;
  reg         op32_reg;
  reg         addr32_reg;
  reg         opbyte_reg;
  reg  [2:0]  gpr_index_reg;
  reg         gpr_byte_reg;
  reg         gpr_high_reg;
  reg  [3:0]  gpr_mask_reg;
  reg  [2:0]  ext_bits_reg;
  reg         ext_valid_reg;
  reg  [2:0]  seg_reg;
  reg         seg_inv_reg;
  reg         modrm_exp_reg;
  reg         sib_exp_reg;
  reg         mem_reg;
  reg  [1:0]  scale_reg;
  reg  [2:0]  index_reg;
  reg  [2:0]  base_reg;
  reg  [1:0]  disp_reg;

  // combinational decode terms
  reg         default32;
  reg         op32_next;
  reg         addr32_next;
  reg  [2:0]  gpr_sel_next;
  reg         modrm_exp_next;
  reg         sib_exp_next;
  reg  [1:0]  disp_next;
  wire [1:0]  mod_field = modrm_i[7:6];
  wire [2:0]  mid_field = modrm_i[5:3];
  wire [2:0]  rm_field  = modrm_i[2:0];
  wire [2:0]  gpr_index_dec;
  wire        gpr_byte_dec;
  wire        gpr_high_dec;
  wire [3:0]  gpr_mask_dec;
  wire [2:0]  seg_dec;
  wire        seg_inv_dec;

  // operation size context
  always @*
  begin
    default32 = ctrl_reg[`OFD_CTRL_LEGACY_BIT] ? 1'b0 : ctrl_reg[`OFD_CTRL_DSIZE_BIT];
    op32_next   = default32 ^ opsize_prefix_i;
    addr32_next = default32 ^ addrsize_prefix_i;
  end

  // register selector source and addressing layout
  always @*
  begin
    if (reg_src_i == `OFD_SRC_MODRM_REG && !modrm_ext_i)
      gpr_sel_next = mid_field;
    else if (reg_src_i == `OFD_SRC_MODRM_RM)
      gpr_sel_next = rm_field;
    else
      gpr_sel_next = opcode_reg_i;
    modrm_exp_next = !implied_mode_i;
    sib_exp_next = modrm_exp_next && addr32_next &&
                   rm_field == `OFD_RM_SIB_ESCAPE && mod_field != `OFD_MOD_REGISTER;
    disp_next = `OFD_DISP_NONE;
    if (!modrm_exp_next || mod_field == `OFD_MOD_REGISTER)
      disp_next = `OFD_DISP_NONE;
    else if (mod_field == 2'h1)
      disp_next = `OFD_DISP_8;
    else if (mod_field == 2'h2)
      disp_next = addr32_next ? `OFD_DISP_32 : `OFD_DISP_16;
    else if (!addr32_next && rm_field == 3'h6)
      disp_next = `OFD_DISP_16;
    else if (addr32_next && !sib_exp_next && rm_field == 3'h5)
      disp_next = `OFD_DISP_32;
    else if (sib_exp_next && sib_i[2:0] == 3'h5)
      disp_next = `OFD_DISP_32;
  end

  ofd_gpr_decode u_gpr
  (
    .sel_i       (gpr_sel_next),
    .w_present_i (w_present_i),
    .w_i         (w_i),
    .op32_i      (op32_next),
    .gpr_index_o (gpr_index_dec),
    .gpr_byte_o  (gpr_byte_dec),
    .gpr_high_o  (gpr_high_dec),
    .wr_mask_o   (gpr_mask_dec)
  );

  ofd_seg_decode u_seg
  (
    .seg2_i    (seg_select_two_bit_i),
    .seg3_i    (seg_select_three_bit_i),
    .use3_i    (seg_use3_i),
    .seg_o     (seg_dec),
    .invalid_o (seg_inv_dec)
  );

  // result flops, loaded once per valid instruction
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      dec_valid_reg <= 1'b0;
      op32_reg      <= 1'b0;
      addr32_reg    <= 1'b0;
      opbyte_reg    <= 1'b0;
      gpr_index_reg <= 3'h0;
      gpr_byte_reg  <= 1'b0;
      gpr_high_reg  <= 1'b0;
      gpr_mask_reg  <= 4'h0;
      ext_bits_reg  <= 3'h0;
      ext_valid_reg <= 1'b0;
      seg_reg       <= 3'h0;
      seg_inv_reg   <= 1'b0;
      modrm_exp_reg <= 1'b0;
      sib_exp_reg   <= 1'b0;
      mem_reg       <= 1'b0;
      scale_reg     <= 2'h0;
      index_reg     <= 3'h0;
      base_reg      <= 3'h0;
      disp_reg      <= 2'h0;
    end
    else
    begin
      dec_valid_reg <= insn_valid_i;
      if (insn_valid_i)
      begin
        op32_reg      <= op32_next;
        addr32_reg    <= addr32_next;
        opbyte_reg    <= w_present_i && !w_i;
        gpr_index_reg <= gpr_index_dec;
        gpr_byte_reg  <= gpr_byte_dec;
        gpr_high_reg  <= gpr_high_dec;
        gpr_mask_reg  <= gpr_mask_dec;
        ext_bits_reg  <= mid_field;
        ext_valid_reg <= modrm_ext_i && !implied_mode_i;
        seg_reg       <= seg_dec;
        seg_inv_reg   <= seg_inv_dec;
        modrm_exp_reg <= modrm_exp_next;
        sib_exp_reg   <= sib_exp_next;
        mem_reg       <= modrm_exp_next && mod_field != `OFD_MOD_REGISTER;
        scale_reg     <= sib_exp_next ? sib_i[7:6] : 2'h0;
        index_reg     <= sib_exp_next ? sib_i[5:3] : 3'h0;
        base_reg      <= sib_exp_next ? sib_i[2:0] : 3'h0;
        disp_reg      <= disp_next;
      end
    end
  end

  // apb slave: one wait cycle in the access phase, data staged at setup
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= `OFD_CTRL_RESET;
      errcnt_reg  <= `OFD_ERRCNT_RESET;
    end
    else
    begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      if (psel_i && !penable_i)
      begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= 32'h0000_0000;
        if (paddr_i == `OFD_CTRL_OFFSET)
          prdata_reg <= {30'h0, ctrl_reg};
        else if (paddr_i == `OFD_STATUS_OFFSET)
        begin
          prdata_reg[`OFD_STAT_ADDR32_BIT] <= addr32_reg;
          prdata_reg[`OFD_STAT_OP32_BIT]   <= op32_reg;
          prdata_reg[`OFD_STAT_SIB_BIT]    <= sib_exp_reg;
          prdata_reg[`OFD_STAT_SEGINV_BIT] <= seg_inv_reg;
          prdata_reg[`OFD_STAT_BYTE_BIT]   <= opbyte_reg;
        end
        else if (paddr_i == `OFD_ERRCNT_OFFSET)
          prdata_reg <= {16'h0, errcnt_reg};
        else
          pslverr_reg <= 1'b1;
      end
      // write takes effect at the completing edge
      if (psel_i && penable_i && pready_reg && pwrite_i &&
          paddr_i == `OFD_CTRL_OFFSET)
        ctrl_reg <= pwdata_i[1:0];
      // count invalid segment codes; a new one beats a clear
      if (insn_valid_i && seg_inv_dec)
        errcnt_reg <= errcnt_reg + 16'h0001;
      else if (psel_i && penable_i && pready_reg && pwrite_i &&
               paddr_i == `OFD_ERRCNT_OFFSET)
        errcnt_reg <= `OFD_ERRCNT_RESET;
    end
  end

  // outputs straight from flops
  assign prdata_o                = prdata_reg;
  assign pready_o                = pready_reg;
  assign pslverr_o               = pslverr_reg;
  assign dec_valid_o             = dec_valid_reg;
  assign op_size_32_o            = op32_reg;
  assign addr_size_32_o          = addr32_reg;
  assign operand_byte_o          = opbyte_reg;
  assign gpr_index_o             = gpr_index_reg;
  assign gpr_byte_o              = gpr_byte_reg;
  assign gpr_high_o              = gpr_high_reg;
  assign gpr_wr_mask_o           = gpr_mask_reg;
  assign opcode_extension_bits_o = ext_bits_reg;
  assign opcode_ext_valid_o      = ext_valid_reg;
  assign seg_sel_o               = seg_reg;
  assign seg_invalid_o           = seg_inv_reg;
  assign modrm_expected_o        = modrm_exp_reg;
  assign sib_expected_o          = sib_exp_reg;
  assign mem_operand_o           = mem_reg;
  assign sib_scale_o             = scale_reg;
  assign sib_index_o             = index_reg;
  assign sib_base_o              = base_reg;
  assign disp_size_o             = disp_reg;

endmodule // ofd_operand_field_decoder

`default_nettype wire

/* File: hw/ofd_seg_decode.v */
/*
  segment selector decode for the two bit and three bit forms; flags the
  reserved three bit codes.
  assumes: purely combinational, driven and sampled by the parent.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ofd_consts.vh"

module ofd_seg_decode
(
  input  wire [1:0] seg2_i,
  input  wire [2:0] seg3_i,
  input  wire       use3_i,
  output reg  [2:0] seg_o,
  output reg        invalid_o
);

  // two bit form maps straight; three bit form adds the auxiliary pair
  always @*
  begin
    seg_o     = {1'b0, seg2_i};
    invalid_o = 1'b0;
    if (use3_i)
    begin
      if (seg3_i[2:1] == 2'h3)
      begin
        // reserved codes fall back to the data segment code and raise invalid
        seg_o     = `OFD_SEG_DATA;
        invalid_o = 1'b1;
      end
      else
      begin
        seg_o     = seg3_i;
      end
    end
  end

endmodule // ofd_seg_decode

`default_nettype wire

/* File: include/ofd_consts.vh */
/*
  constants of the operand field decoder: register offsets, field positions,
  reset values and the codes that the decoder puts out.
  assumes: included by bare name from every design file that needs it.
*/
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH

// apb register byte offsets
`define OFD_CTRL_OFFSET       12'h000
`define OFD_STATUS_OFFSET     12'h004
`define OFD_ERRCNT_OFFSET     12'h008

// control register fields and reset value
`define OFD_CTRL_DSIZE_BIT    0
`define OFD_CTRL_LEGACY_BIT   1
`define OFD_CTRL_RESET        2'h0

// status register fields
`define OFD_STAT_ADDR32_BIT   0
`define OFD_STAT_OP32_BIT     1
`define OFD_STAT_SIB_BIT      2
`define OFD_STAT_SEGINV_BIT   3
`define OFD_STAT_BYTE_BIT     4

// error counter reset value
`define OFD_ERRCNT_RESET      16'h0000

// sources of the general register selector
`define OFD_SRC_OPCODE        2'h0
`define OFD_SRC_MODRM_REG     2'h1
`define OFD_SRC_MODRM_RM      2'h2

// segment register codes on the output
`define OFD_SEG_EXTRA         3'h0
`define OFD_SEG_CODE          3'h1
`define OFD_SEG_STACK         3'h2
`define OFD_SEG_DATA          3'h3
`define OFD_SEG_AUX_ONE       3'h4
`define OFD_SEG_AUX_TWO       3'h5

// addressing field codes
`define OFD_MOD_REGISTER      2'h3
`define OFD_RM_SIB_ESCAPE     3'h4

// displacement size codes
`define OFD_DISP_NONE         2'h0
`define OFD_DISP_8            2'h1
`define OFD_DISP_16           2'h2
`define OFD_DISP_32           2'h3

// register write lane masks
`define OFD_MASK_LOW_BYTE     4'h1
`define OFD_MASK_HIGH_BYTE    4'h2
`define OFD_MASK_WORD         4'h3
`define OFD_MASK_DWORD        4'hf

`endif
